// ### edge_event_interrupt_unit.v
// Overview of operation
// - Nineteen lines raise interrupt or event requests.
// - Per-line choice of rising, falling or both.
// - Per-line mask blocks only that line.
// - Pending bit set on each selected edge.
// - Async latch catches pulses shorter than clock.
// - Sixteen lines each select one of 51 pins.
//
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
`include "edge_event_defs.vh"
module edge_event_interrupt_unit
(
    input  wire        i_sys_clk,
    input  wire        i_reset_n,
    input  wire        i_psel,
    input  wire        i_penable,
    input  wire        i_pwrite,
    input  wire [11:0] i_paddr,
    input  wire [31:0] i_pwdata,
    output reg         o_pready,
    output reg  [31:0] o_prdata,
    output reg         o_pslverr,
    input  wire [50:0] i_gpio_pins,
    input  wire [2:0]  i_internal_lines,
    output reg  [18:0] o_int_req,
    output reg  [18:0] o_event_req,
    output reg         o_irq
);

    reg  [18:0] rise_en;
    reg  [18:0] fall_en;
    reg  [18:0] int_mask;
    reg  [18:0] evt_mask;
    reg  [18:0] pending;
    reg  [18:0] irq_status;
    reg  [18:0] irq_mask;
    reg  [5:0]  pin_sel [0:15];
    wire [18:0] line_in;
    wire [18:0] rise_seen;
    wire [18:0] fall_seen;
    wire [18:0] edge_hit;
    reg  [31:0] next_rdata;
    reg         next_err;
    wire        access;
    wire        wr_done;
    wire        rd_done;
    wire [18:0] wdata;

    assign access  = i_psel & i_penable;
    assign wr_done = access & o_pready & i_pwrite;
    assign rd_done = access & o_pready & ~i_pwrite;
    assign wdata   = i_pwdata[18:0];

    genvar g;
    generate
        for (g = 0; g < `EE_NUM_LINES; g = g + 1)
        begin : g_line
            if (g < `EE_NUM_EXT_LINES)
            begin : g_ext
                // Out-of-range selections fall back to pin zero.
                assign line_in[g] = (pin_sel[g] < `EE_NUM_PINS) ?
                                    i_gpio_pins[pin_sel[g]] : i_gpio_pins[0];
                always @(posedge i_sys_clk or negedge i_reset_n)
                begin
                    if (!i_reset_n)
                        pin_sel[g] <= `EE_RST_SEL;
                    else if (wr_done &&
                             i_paddr == (`EE_OFF_PIN_SEL0 + 12'h004 * (g / 4)))
                        pin_sel[g] <= i_pwdata[(g % 4) * `EE_SEL_FIELD_W +: `EE_SEL_W];
                end
            end
            else
            begin : g_int
                assign line_in[g] = i_internal_lines[g - `EE_NUM_EXT_LINES];
            end
            edge_line_capture u_capture
            (
                .i_sys_clk (i_sys_clk),
                .i_reset_n (i_reset_n),
                .i_line    (line_in[g]),
                .o_rise    (rise_seen[g]),
                .o_fall    (fall_seen[g])
            );
            assign edge_hit[g] = (rise_seen[g] & rise_en[g]) |
                                 (fall_seen[g] & fall_en[g]);
        end
    endgenerate

    // Configuration registers.
    always @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            rise_en  <= `EE_RST_LINES;
            fall_en  <= `EE_RST_LINES;
            int_mask <= `EE_RST_LINES;
            evt_mask <= `EE_RST_LINES;
            irq_mask <= `EE_RST_LINES;
        end
        else if (wr_done)
        begin
            case (i_paddr)
                `EE_OFF_RISE_EN:  rise_en  <= wdata;
                `EE_OFF_FALL_EN:  fall_en  <= wdata;
                `EE_OFF_INT_MASK: int_mask <= wdata;
                `EE_OFF_EVT_MASK: evt_mask <= wdata;
                `EE_OFF_IRQ_MASK: irq_mask <= wdata;
                default:          irq_mask <= irq_mask;
            endcase
        end
    end

    // Pending and summary status; a new edge wins over a clear in the same cycle.
    always @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            pending    <= `EE_RST_LINES;
            irq_status <= `EE_RST_LINES;
        end
        else
        begin
            if (wr_done && i_paddr == `EE_OFF_PENDING)
                pending <= (pending & ~wdata) | edge_hit;
            else
                pending <= pending | edge_hit;
            if (rd_done && i_paddr == `EE_OFF_IRQ_STAT)
                irq_status <= (irq_status & ~o_prdata[18:0]) | edge_hit;
            else
                irq_status <= irq_status | edge_hit;
        end
    end

    // Request outputs toward the processor.
    always @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_int_req   <= `EE_RST_LINES;
            o_event_req <= `EE_RST_LINES;
            o_irq       <= 1'b0;
        end
        else
        begin
            o_int_req   <= pending & int_mask;
            o_event_req <= edge_hit & evt_mask;
            o_irq       <= |(irq_status & irq_mask);
        end
    end

    // Read decode.
    always @*
    begin
        next_rdata = `EE_RST_WORD;
        next_err   = 1'b0;
        case (i_paddr)
            `EE_OFF_RISE_EN:  next_rdata = {13'h0000, rise_en};
            `EE_OFF_FALL_EN:  next_rdata = {13'h0000, fall_en};
            `EE_OFF_INT_MASK: next_rdata = {13'h0000, int_mask};
            `EE_OFF_EVT_MASK: next_rdata = {13'h0000, evt_mask};
            `EE_OFF_PENDING:  next_rdata = {13'h0000, pending};
            `EE_OFF_IRQ_STAT: next_rdata = {13'h0000, irq_status};
            `EE_OFF_IRQ_MASK: next_rdata = {13'h0000, irq_mask};
            `EE_OFF_PIN_SEL0: next_rdata = {2'h0, pin_sel[3], 2'h0, pin_sel[2],
                                            2'h0, pin_sel[1], 2'h0, pin_sel[0]};
            `EE_OFF_PIN_SEL1: next_rdata = {2'h0, pin_sel[7], 2'h0, pin_sel[6],
                                            2'h0, pin_sel[5], 2'h0, pin_sel[4]};
            `EE_OFF_PIN_SEL2: next_rdata = {2'h0, pin_sel[11], 2'h0, pin_sel[10],
                                            2'h0, pin_sel[9], 2'h0, pin_sel[8]};
            `EE_OFF_PIN_SEL3: next_rdata = {2'h0, pin_sel[15], 2'h0, pin_sel[14],
                                            2'h0, pin_sel[13], 2'h0, pin_sel[12]};
            default:          next_err   = 1'b1;
        endcase
    end

    // Bus answer with one wait state.
    always @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_pready  <= 1'b0;
            o_prdata  <= `EE_RST_WORD;
            o_pslverr <= 1'b0;
        end
        else if (access && !o_pready)
        begin
            o_pready  <= 1'b1;
            o_prdata  <= i_pwrite ? `EE_RST_WORD : next_rdata;
            o_pslverr <= next_err;
        end
        else
        begin
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
        end
    end

endmodule // edge_event_interrupt_unit

// ### edge_event_defs.vh
`ifndef EDGE_EVENT_DEFS_VH
`define EDGE_EVENT_DEFS_VH

// Line counts and pin selection geometry.
`define EE_NUM_LINES      19
`define EE_NUM_EXT_LINES  16
`define EE_NUM_PINS       51
`define EE_SEL_W          6
`define EE_SEL_FIELD_W    8

// Register byte offsets.
`define EE_OFF_RISE_EN    12'h000
`define EE_OFF_FALL_EN    12'h004
`define EE_OFF_INT_MASK   12'h008
`define EE_OFF_EVT_MASK   12'h00C
`define EE_OFF_PENDING    12'h010
`define EE_OFF_IRQ_STAT   12'h018
`define EE_OFF_IRQ_MASK   12'h01C
`define EE_OFF_PIN_SEL0   12'h020
`define EE_OFF_PIN_SEL1   12'h024
`define EE_OFF_PIN_SEL2   12'h028
`define EE_OFF_PIN_SEL3   12'h02C

// Reset values.
`define EE_RST_LINES      19'h00000
`define EE_RST_SEL        6'h00
`define EE_RST_WORD       32'h00000000

`endif

// ### edge_line_capture.v
`timescale 1ns/1ns
module edge_line_capture
(
    input  wire i_sys_clk,
    input  wire i_reset_n,
    input  wire i_line,
    output reg  o_rise,
    output reg  o_fall
);

    reg       rise_toggle;
    reg       fall_toggle;
    reg [2:0] rise_sync;
    reg [2:0] fall_sync;

    // The line itself clocks a toggle, so a pulse shorter than a bus clock is kept.
    always @(posedge i_line or negedge i_reset_n)
    begin
        if (!i_reset_n)
            rise_toggle <= 1'b0;
        else
            rise_toggle <= ~rise_toggle;
    end

    always @(negedge i_line or negedge i_reset_n)
    begin
        if (!i_reset_n)
            fall_toggle <= 1'b0;
        else
            fall_toggle <= ~fall_toggle;
    end

    // Two flops synchronise each toggle; the third keeps the previous value.
    always @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            rise_sync <= 3'h0;
            fall_sync <= 3'h0;
            o_rise    <= 1'b0;
            o_fall    <= 1'b0;
        end
        else
        begin
            rise_sync <= {rise_sync[1:0], rise_toggle};
            fall_sync <= {fall_sync[1:0], fall_toggle};
            o_rise    <= rise_sync[2] ^ rise_sync[1];
            o_fall    <= fall_sync[2] ^ fall_sync[1];
        end
    end

endmodule // edge_line_capture

// ### edge_event_interrupt_unit_checker.sv
`timescale 1ns/1ns
module edge_event_interrupt_unit_checker
(
    input logic        i_sys_clk,
    input logic        i_reset_n,
    input logic        i_psel,
    input logic        i_penable,
    input logic        i_pwrite,
    input logic        o_pready,
    input logic        o_pslverr,
    input logic        o_irq,
    input logic [18:0] o_int_req
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_reset_n);
    a_err_with_ready: assert property (o_pslverr |-> o_pready)
        else $error("error without ready");
    a_ready_one_cycle: assert property (o_pready |=> !o_pready)
        else $error("ready too long");
    a_ready_in_access: assert property (o_pready |-> $past(i_psel) && $past(i_penable))
        else $error("ready outside access");
    a_one_wait_state: assert property ($rose(i_penable) && i_psel |-> !o_pready ##1 o_pready)
        else $error("wrong wait states");
    a_reset_quiet: assert property ($rose(i_reset_n) |-> o_int_req == 0 && !o_irq)
        else $error("request after reset");
    a_int_falls_write: assert property (|($past(o_int_req) & ~o_int_req) |->
        $past(i_pwrite, 2) && $past(i_penable, 2))
        else $error("request dropped without write");
    a_irq_falls_bus: assert property ($fell(o_irq) |-> $past(i_psel, 2))
        else $error("irq dropped without access");
endmodule // edge_event_interrupt_unit_checker
bind edge_event_interrupt_unit edge_event_interrupt_unit_checker watch (.i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .o_irq(o_irq), .o_int_req(o_int_req));

// ### pin_source_model.sv
`timescale 1ns/1ns
module pin_source_model
(
    output logic [50:0] o_pins,
    output logic [2:0]  o_inner
);
    logic [53:0] level = 54'h0;
    assign o_pins = level[50:0];
    assign o_inner = level[53:51];
    task automatic drive(input int idx, input logic v);
        level[idx] <= v;
    endtask
    // Pulse far shorter than a clock period.
    task automatic pulse(input int idx);
        level[idx] <= 1'b1;
        #1 level[idx] <= 1'b0;
    endtask
endmodule // pin_source_model

// ### edge_event_interrupt_unit_test.sv
`timescale 1ns/1ns
module edge_event_interrupt_unit_test;
    logic        clk = 0, rst_n, psel = 0, penable = 0, pwrite = 0;
    logic        pready, pslverr, irq;
    logic [11:0] paddr = 0, a;
    logic [31:0] pwdata = 0, prdata, r, k, e;
    logic [50:0] pins;
    logic [2:0]  inner;
    logic [18:0] int_req, evt, evt_last = 0;
    logic [32:0] notes[$];
    int          fails = 0, samples_checked = 0, seed = 32'hE631, m, evt_n = 0;
    always #2 clk = ~clk;
    pin_source_model src (.o_pins(pins), .o_inner(inner));
    edge_event_interrupt_unit DUT (.i_sys_clk(clk), .i_reset_n(rst_n), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr), .i_gpio_pins(pins),
        .i_internal_lines(inner), .o_int_req(int_req), .o_event_req(evt), .o_irq(irq));
    task automatic chk(input string n, input logic [32:0] x, input logic [32:0] g);
        samples_checked++;
        if (g !== x)
        begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d,
                       input logic [32:0] x);
        notes.push_back(x);
        @(posedge clk);
        psel <= 1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        psel <= 0;
        penable <= 0;
    endtask
    always @(posedge clk)
        if (pready === 1'b1)
            chk("apb", notes.pop_front(), {pslverr, prdata});
    // Event pulses last one cycle, so they are counted here as they appear.
    always @(posedge clk)
        if (evt !== 19'h0)
        begin
            evt_n <= evt_n + 1;
            evt_last <= evt;
        end
    task automatic look(input logic [31:0] p, input logic [31:0] q, input logic v);
        int n0;
        n0 = evt_n;
        repeat (8) @(posedge clk);
        chk("int_req", {14'h0, q[18:0]}, {14'h0, int_req});
        chk("irq", {32'h0, v}, {32'h0, irq});
        chk("event_count", {32'h0, q != 0}, 33'(evt_n - n0));
        if (q != 0)
            chk("event_req", {14'h0, q[18:0]}, {14'h0, evt_last});
        apb(0, 12'h010, 0, {1'b0, p});
        apb(1, 12'h010, 0, 0);
        apb(0, 12'h010, 0, {1'b0, p});
        apb(1, 12'h010, 32'h7FFFF, 0);
        apb(0, 12'h010, 0, 0);
        apb(0, 12'h018, 0, {1'b0, p});
        apb(0, 12'h018, 0, 0);
        repeat (3) @(posedge clk);
        chk("irq_clear", 0, {32'h0, irq});
    endtask
    task automatic test_done;
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1;
        for (m = 0; m < 9; m++)
        begin
            a = m < 4 ? 12'(m * 4) : (m == 4 ? 12'h01C : 12'(32 + (m - 5) * 4));
            k = m < 5 ? 32'h7FFFF : 32'h3F3F3F3F;
            r = $random(seed);
            apb(0, a, 0, 0);
            apb(1, a, r, 0);
            apb(0, a, 0, {1'b0, r & k});
        end
        apb(0, 12'h030, 0, {1'b1, 32'h0});
        apb(1, 12'h014, r, {1'b1, 32'h0});
        $display("register test done");
        apb(1, 12'h020, 32'h2500, 0);
        for (m = 1; m < 4; m++)
            apb(1, 12'(32 + m * 4), 0, 0);
        for (m = 0; m < 3; m++)
            apb(1, 12'(8 + m * 4 + (m / 2) * 12), 2, 0);
        apb(1, 12'h010, 32'h7FFFF, 0);
        for (m = 0; m < 3; m++)
        begin
            apb(1, 12'h000, m != 1 ? 32'h2 : 0, 0);
            apb(1, 12'h004, m != 0 ? 32'h2 : 0, 0);
            src.drive(37, 1);
            e = m != 1 ? 32'h2 : 0;
            look(e, e, e[1]);
            src.drive(37, 0);
            e = m != 0 ? 32'h2 : 0;
            look(e, e, e[1]);
            $display("edge mode %0d done", m);
        end
        apb(1, 12'h000, 32'h20000, 0);
        src.pulse(52);
        look(32'h20000, 0, 0);
        $display("narrow pulse test done");
        test_done;
    end
    initial
    begin
        #20000;
        fails++;
        test_done;
    end
endmodule // edge_event_interrupt_unit_test
